// ---- verilog/cesr_channel_event_status.sv ----
// per-channel change-event latching and live alarm reporting, twelve channels
// assumes condition and enable inputs synchronous to mclk, and a host read
// strobe up_rd of one cycle with up_addr stable in that cycle
`timescale 1ns/10ps

module cesr_channel_event_status (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // live conditions, one bit per channel
  input  wire logic [11:0] fifo_limit_alarm,
  input  wire logic [11:0] receive_lock_lost,
  input  wire logic [11:0] receive_signal_lost,
  input  wire logic [11:0] transmit_drive_monitor,
  input  wire logic [11:0] prbs_sync_lost,
  input  wire logic [11:0] digital_signal_lost,
  input  wire logic [11:0] analog_signal_lost,
  // enables, four bits per channel in event-latch bit order
  input  wire logic [47:0] channel_event_enable,
  // parallel register port, read side
  input  wire logic [7:0]  up_addr,
  input  wire logic        up_rd,
  output logic      [7:0]  up_rdata,
  output logic             up_rvalid
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic [3:0] sel_ch;
  logic       sel_valid;
  logic       rd_event;
  logic       rd_alarm;
  logic [3:0] hi_nib;

  // unmapped channel nibbles (6, 7, E, F) select nothing and read as zero
  always_comb begin
    hi_nib    = up_addr[7:4];
    sel_ch    = 4'h0;
    sel_valid = 1'b0;
    if (hi_nib <= cesr_pkg::M_LOW_LAST) begin
      sel_valid = 1'b1;
      sel_ch    = hi_nib;
    end else if (hi_nib >= cesr_pkg::M_HIGH_FIRST && hi_nib <= cesr_pkg::M_HIGH_LAST) begin
      sel_valid = 1'b1;
      sel_ch    = hi_nib - cesr_pkg::M_BANK_GAP;
    end
    rd_event = up_rd && sel_valid && (up_addr[3:0] == cesr_pkg::REG_EVENT);
    rd_alarm = up_rd && sel_valid && (up_addr[3:0] == cesr_pkg::REG_ALARM);
  end

  // ****************************************************************
  // change detection primer
  // ****************************************************************
  logic primed_q;
  logic primed_d;

  // the first cycle after reset only loads the previous-state flops, so a
  // condition already standing at reset release is not taken as a change
  always_comb begin
    primed_d = 1'b1;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      primed_q <= 1'b0;
    end else begin
      primed_q <= primed_d;
    end
  end

  // ****************************************************************
  // per-channel state
  // ****************************************************************
  logic [3:0] latch_q [cesr_pkg::NUM_CH];
  logic [6:0] alarm_q [cesr_pkg::NUM_CH];

  // one slice per channel; conditions are gathered here in alarm bit order,
  // so the low four bits of each slice's input are its event conditions
  for (genvar i = 0; i < cesr_pkg::NUM_CH; i++) begin : g_ch
    logic [6:0] live_w;
    logic       clr_w;

    always_comb begin
      live_w[cesr_pkg::BIT_FIFO_LIM]  = fifo_limit_alarm[i];
      live_w[cesr_pkg::BIT_LOCK_LOST] = receive_lock_lost[i];
      live_w[cesr_pkg::BIT_SIG_LOST]  = receive_signal_lost[i];
      live_w[cesr_pkg::BIT_DRV_MON]   = transmit_drive_monitor[i];
      live_w[cesr_pkg::BIT_ANA_LOST]  = analog_signal_lost[i];
      live_w[cesr_pkg::BIT_DIG_LOST]  = digital_signal_lost[i];
      live_w[cesr_pkg::BIT_PRBS_LOST] = prbs_sync_lost[i];
      // only a read of this channel's event latch clears it
      clr_w = rd_event && (sel_ch == 4'(i));
    end

    cesr_chan_slice #(
      .EV_BITS (cesr_pkg::EV_W),
      .AL_BITS (cesr_pkg::AL_W)
    ) i_cesr_chan_slice (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .primed  (primed_q),
      .clr     (clr_w),
      .live    (live_w),
      .enable  (channel_event_enable[i*cesr_pkg::EV_W +: cesr_pkg::EV_W]),
      .latch   (latch_q[i]),
      .alarm   (alarm_q[i])
    );
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;

  // data holds until the next read; the latch is sampled before its clear
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = up_rd;
    if (up_rd) begin
      rdata_d = cesr_pkg::RDATA_RST;
      if (rd_event) begin
        rdata_d = {cesr_pkg::EV_RSVD, latch_q[sel_ch]};
      end else if (rd_alarm) begin
        rdata_d = {cesr_pkg::AL_RSVD, alarm_q[sel_ch]};
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q  <= cesr_pkg::RDATA_RST;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign up_rdata  = rdata_q;
  assign up_rvalid = rvalid_q;

endmodule

// ****************************************************************
// channel slice: change detection, event latch and live alarm copy
// ****************************************************************
// the slice knows nothing of addresses; the top decides which read clears it
module cesr_chan_slice #(
  parameter int unsigned EV_BITS = cesr_pkg::EV_W,  // latched change events
  parameter int unsigned AL_BITS = cesr_pkg::AL_W   // live alarm bits
) (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  // shared primer and per-channel clear from the top
  input  wire logic               primed,
  input  wire logic               clr,
  // live conditions in alarm bit order, the low bits being the event sources
  input  wire logic [AL_BITS-1:0] live,
  input  wire logic [EV_BITS-1:0] enable,
  // registered event latch and alarm copy
  output logic      [EV_BITS-1:0] latch,
  output logic      [AL_BITS-1:0] alarm
);

  // ****************************************************************
  // change detection and latching
  // ****************************************************************
  logic [EV_BITS-1:0] prev_q;
  logic [EV_BITS-1:0] prev_d;
  logic [EV_BITS-1:0] latch_q;
  logic [EV_BITS-1:0] latch_d;
  logic [AL_BITS-1:0] alarm_q;
  logic [AL_BITS-1:0] alarm_d;
  logic [EV_BITS-1:0] change;

  // a condition declared and cleared again between two reads leaves its bit
  // set although the alarm copy shows it gone: the latch records that
  // something happened, the alarm copy what stands now
  always_comb begin
    prev_d  = live[EV_BITS-1:0];
    // declare and clear edges both count, but not in the primer cycle
    change  = (prev_d ^ prev_q) & {EV_BITS{primed}};
    // set wins: a new enabled change in the read cycle survives the clear
    latch_d = (clr ? EV_BITS'(cesr_pkg::EVENT_RST) : latch_q)
            | (change & enable);
    alarm_d = live;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // a reset drops every pending event, so a change that straddles it is
  // lost; only the alarm copy tells the host what stands afterwards
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q  <= EV_BITS'(cesr_pkg::EVENT_RST);
      latch_q <= EV_BITS'(cesr_pkg::EVENT_RST);
      alarm_q <= AL_BITS'(cesr_pkg::ALARM_RST);
    end else begin
      prev_q  <= prev_d;
      latch_q <= latch_d;
      alarm_q <= alarm_d;
    end
  end

  assign latch = latch_q;
  assign alarm = alarm_q;

endmodule

// ---- pkg/cesr_pkg.sv ----
// constants for the per-channel event latch and alarm state registers
// assumes an 8-bit register address: high nibble channel, low nibble register
package cesr_pkg;

  // ****************************************************************
  // channel layout
  // ****************************************************************
  localparam int unsigned NUM_CH = 12;
  localparam int unsigned EV_W   = 4;   // latched change events per channel
  localparam int unsigned AL_W   = 7;   // live alarm bits per channel

  // ****************************************************************
  // address decode
  // ****************************************************************
  localparam logic [3:0] M_LOW_LAST   = 4'h5;  // first bank: channels 0..5
  localparam logic [3:0] M_HIGH_FIRST = 4'h8;  // second bank: channels 6..11
  localparam logic [3:0] M_HIGH_LAST  = 4'hD;
  localparam logic [3:0] M_BANK_GAP   = 4'h2;  // high nibble 8 maps to channel 6
  localparam logic [3:0] REG_EVENT    = 4'h2;  // channel_event_latch
  localparam logic [3:0] REG_ALARM    = 4'h3;  // channel_alarm_state

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int unsigned BIT_DRV_MON   = 0;
  localparam int unsigned BIT_SIG_LOST  = 1;
  localparam int unsigned BIT_LOCK_LOST = 2;
  localparam int unsigned BIT_FIFO_LIM  = 3;
  localparam int unsigned BIT_ANA_LOST  = 4;
  localparam int unsigned BIT_DIG_LOST  = 5;
  localparam int unsigned BIT_PRBS_LOST = 6;
  localparam logic [3:0] EVENT_RST = 4'h0;
  localparam logic [6:0] ALARM_RST = 7'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [3:0] EV_RSVD   = 4'h0;  // bits 7..4 of the event latch
  localparam logic       AL_RSVD   = 1'h0;  // bit 7 of the alarm state

endpackage

// ---- sim/cesr_host.sv ----
// host model: issues register reads on the parallel port
// assumes one read per mclk edge, signals changed just after the edge
`timescale 1ns/10ps
module cesr_host (
  // clock
  input  wire logic       mclk,
  // read request
  output logic      [7:0] up_addr,
  output logic            up_rd
);
  // idle until the bench asks for a read
  initial begin
    up_rd   = 1'b0;
    up_addr = 8'h00;
  end
  // back-to-back reads keep the strobe up
  task rd(input logic [7:0] a);
    @(posedge mclk);
    up_rd   <= 1'b1;
    up_addr <= a;
  endtask
  // released address is inverted so no stale value lingers
  task idle;
    @(posedge mclk);
    up_rd   <= 1'b0;
    up_addr <= ~up_addr;
  endtask
endmodule

// ---- sim/cesr_chk.sv ----
// checker for the read port, live alarm and event latch of channel 0
// assumes binding onto the block top
`timescale 1ns/10ps
module cesr_chk (
  // clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // channel conditions and enables
  input wire logic [11:0] fifo_limit_alarm,
  input wire logic [11:0] receive_lock_lost,
  input wire logic [11:0] receive_signal_lost,
  input wire logic [11:0] transmit_drive_monitor,
  input wire logic [47:0] channel_event_enable,
  // register port
  input wire logic [7:0]  up_addr,
  input wire logic        up_rd,
  input wire logic [7:0]  up_rdata,
  input wire logic        up_rvalid
);
  logic [3:0] c0;
  // channel 0 conditions in latch bit order
  assign c0 = {fifo_limit_alarm[0], receive_lock_lost[0], receive_signal_lost[0],
               transmit_drive_monitor[0]};
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_ev;
    up_rd && up_addr == 8'h02;
  endsequence
  sequence s_chg_fl;
    $changed(c0[3]) && channel_event_enable[3];
  endsequence
  a_valid_after_rd: assert property (up_rd |=> up_rvalid) else $error("no valid");
  a_no_spurious_valid: assert property (!up_rd |=> !up_rvalid) else $error("stray valid");
  a_event_rsvd_zero: assert property (up_rd && up_addr[3:0] == 4'h2 |=> up_rdata[7:4] == 4'h0)
    else $error("event high bits");
  a_alarm_rsvd_zero: assert property (up_rd && up_addr[3:0] == 4'h3 |=> !up_rdata[7])
    else $error("alarm bit 7");
  a_unmapped_zero: assert property (up_rd && up_addr[6:5] == 2'b11 |=> up_rdata == 8'h00)
    else $error("unmapped data");
  a_alarm_live: assert property (up_rd && up_addr == 8'h03 |=> up_rdata[3:0] == $past(c0, 2))
    else $error("alarm value");
  a_event_sets: assert property ($changed(c0[3]) && channel_event_enable[3] ##1 s_ev |=> up_rdata[3])
    else $error("event lost");
  a_event_clears: assert property ((s_ev and $stable(c0)) ##1 s_ev |=> up_rdata == 8'h00)
    else $error("event kept");
  a_event_held: assert property (s_chg_fl ##1 !up_rd ##1 s_ev |=> up_rdata[3])
    else $error("event not held");
  a_set_beats_clear: assert property ((s_ev and s_chg_fl) ##1 s_ev |=> up_rdata[3])
    else $error("event lost in clear");
endmodule
bind cesr_channel_event_status cesr_chk i_chk (.mclk, .sys_rst, .fifo_limit_alarm,
  .receive_lock_lost, .receive_signal_lost, .transmit_drive_monitor, .channel_event_enable,
  .up_addr, .up_rd, .up_rdata, .up_rvalid);

// ---- sim/cesr_channel_event_status_tb.sv ----
// bench: random conditions and enables per channel, reads through the host model
// assumes the host model issues one read per edge
`timescale 1ns/10ps
module cesr_channel_event_status_tb;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] cnd [7];
  logic [47:0] en = 48'h0;
  logic [7:0]  up_addr, up_rdata;
  logic        up_rd, up_rvalid;
  logic [3:0]  lat [12];
  logic [7:0]  exp_q [$];
  int          seed = 32'hAA74;
  int          error_cnt = 0;
  int          samples_checked = 0;
  always #12.5 mclk = ~mclk;
  cesr_host i_cesr_host (.mclk, .up_addr, .up_rd);
  cesr_channel_event_status i_cesr_channel_event_status (.mclk, .sys_rst,
    .fifo_limit_alarm(cnd[3]), .receive_lock_lost(cnd[2]), .receive_signal_lost(cnd[1]),
    .transmit_drive_monitor(cnd[0]), .analog_signal_lost(cnd[4]),
    .digital_signal_lost(cnd[5]), .prbs_sync_lost(cnd[6]), .channel_event_enable(en),
    .up_addr, .up_rd, .up_rdata, .up_rvalid);
  task complete_run;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // change one channel, then read events twice, alarms, and an unmapped place
  task step(input int ch, input logic [31:0] r);
    logic [7:0] a;
    a = {ch < 6 ? ch[3:0] : ch[3:0] + 4'h2, 4'h2};
    @(posedge mclk);
    for (int k = 0; k < 7; k++) cnd[k][ch] <= r[k];
    for (int k = 0; k < 4; k++) lat[ch][k] = lat[ch][k] | ((cnd[k][ch] ^ r[k]) & r[k+7]);
    en[4*ch +: 4] <= r[10:7];
    @(posedge mclk);
    exp_q.push_back({4'h0, lat[ch]});
    lat[ch] = 4'h0;
    i_cesr_host.rd(a);
    exp_q.push_back(8'h00);
    i_cesr_host.rd(a);
    exp_q.push_back({1'b0, r[6:0]});
    i_cesr_host.rd(a | 8'h01);
    exp_q.push_back(8'h00);
    i_cesr_host.rd({ch[1], 2'b11, ch[0], 4'h2});
    i_cesr_host.idle;
  endtask
  // an enabled change on the edge of the clearing read must show at the next read
  task race;
    @(posedge mclk);
    en[3] <= 1'b1;
    exp_q.push_back({4'h0, lat[0]});
    i_cesr_host.rd(8'h02);
    cnd[3][0] <= ~cnd[3][0];
    exp_q.push_back(8'h08);
    i_cesr_host.rd(8'h02);
    i_cesr_host.idle;
  endtask
  task cmp(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t read %h expected %h", $time, g, e);
    end
  endtask
  // results are taken at the falling edge, well after the registers settle
  always @(negedge mclk) begin
    if (up_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("BAD %0t unexpected read", $time);
      end else cmp(exp_q.pop_front(), up_rdata);
    end
  end
  initial begin
    for (int k = 0; k < 7; k++) cnd[k] = 12'h000;
    for (int c = 0; c < 12; c++) lat[c] = 4'h0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int n = 0; n < 48; n++) step(n % 12, $random(seed));
    race;
    step(0, {21'h0, 4'hF, 3'h0, ~cnd[3][0], 3'h0});
    for (int t = 0; t < 8 && exp_q.size() != 0; t++) @(posedge mclk);
    if (exp_q.size() != 0) error_cnt++;
    complete_run;
  end
  // watchdog against a hung read port
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    complete_run;
  end
endmodule
